// ===== pacf_cmd_regs.sv
/*
  Command registers for the device bus address, the settings checksum and
  fault injection. Assumes a bus front end that turns each transaction into
  a one-cycle strobe with command code and data, an NVM engine that streams
  the settings bytes on request, and protection logic that pulses a response
  per detector.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bus-address command EF: byte write sets, byte read returns own address.
// - A new address is used from the cycle after the write.
// - Address bit 7 is read-only and always reads zero.
// - Address bits 6:0 load from stored value or pin straps at start.
// - Reserved addresses 0x0C and 0x28 are refused.
// - Reserved addresses 0x37 and 0x61 are refused too.
// - Word read F0 returns CRC-16, polynomial 0x8005; it cannot be written.
// - Checksum is recomputed at boot and after every store or restore.
// - Word command F1 injects faults; volatile; set bits force detectors.
// - Several injections may be active together, each independent.
// - Bit 15 clear: faults end after one response; set: until rewritten.
// - Bit 7 clear: warnings end after one response; set: until rewritten.
// - Bit 14 injects overtemperature, bit 12 overcurrent fault; zero no change.
// - Bit 11 injects input lockout, bit 10 input overvoltage; zero no change.
// - Bit 9 injects output undervoltage, bit 8 output overvoltage fault.
// - Bit 4 injects overcurrent warning, bit 3 input undervoltage warning.
// - Bit 1 injects output undervoltage, bit 0 output overvoltage warning.
// - Only input lockout and output overvoltage force while conversion is off.
// - All other injections act only while conversion is on.
// - Pin-override mask bit 8 picks the strapped address at load.
module pacf_cmd_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Command strobes from the bus front end
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_en_i,
  input wire logic wr_word_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic rd_word_i,
  // Read answer and error
  output logic [15:0] rd_data_o,
  output logic rd_ack_o,
  output logic cmd_err_o,
  // Address load sources
  input wire logic addr_load_i,
  input wire logic [6:0] nvm_addr_i,
  input wire logic [6:0] pin_addr_i,
  input wire logic [15:0] pin_override_i,
  output logic [6:0] own_addr_o,
  // Settings stream from the NVM engine
  input wire logic boot_done_i,
  input wire logic nvm_op_done_i,
  input wire logic nvm_byte_valid_i,
  input wire logic [7:0] nvm_byte_i,
  input wire logic nvm_byte_last_i,
  output logic crc_req_o,
  output logic crc_busy_o,
  // Protection logic
  input wire logic conv_en_i,
  input wire logic [15:0] fault_resp_i,
  output logic [15:0] inj_force_o
);

  // Command decode
  wire is_addr_cmd = (cmd_code_i == pacf_pkg::CMD_BUS_ADDRESS_SELECT);
  wire is_crc_cmd = (cmd_code_i == pacf_pkg::CMD_SETTINGS_CRC);
  wire is_inj_cmd = (cmd_code_i == pacf_pkg::CMD_FAULT_INJECTION);
  wire [6:0] new_addr = wr_data_i[6:0];
  wire addr_rsv = (new_addr == pacf_pkg::RSV_ADDR_A) ||
                  (new_addr == pacf_pkg::RSV_ADDR_B) ||
                  (new_addr == pacf_pkg::RSV_ADDR_C) ||
                  (new_addr == pacf_pkg::RSV_ADDR_D);
  wire addr_wr_ok = wr_en_i && is_addr_cmd && !wr_word_i && !addr_rsv;
  wire inj_wr = wr_en_i && is_inj_cmd && wr_word_i;
  wire wr_err = wr_en_i && !addr_wr_ok && !inj_wr;
  wire rd_ok = rd_en_i && ((is_addr_cmd && !rd_word_i) ||
                           ((is_crc_cmd || is_inj_cmd) && rd_word_i));
  wire rd_err = rd_en_i && !rd_ok;

  // Registers
  logic [6:0] addr_ff;
  logic [15:0] crc_ff;
  logic fault_persist_ff;
  logic warn_persist_ff;
  logic [15:0] inj_rsv_ff;
  logic [15:0] rd_data_ff;
  logic rd_ack_ff;
  logic cmd_err_ff;
  logic crc_req_ff;
  logic crc_busy_ff;
  pacf_pkg::pacf_crc_state_type crc_st_ff;

  // Address next value: load, valid write, or hold
  wire use_pins = pin_override_i[pacf_pkg::OVR_ADDRESS_BIT];
  wire [6:0] load_addr = use_pins ? pin_addr_i : nvm_addr_i;
  wire [6:0] nxt_addr = addr_load_i ? load_addr :
                        addr_wr_ok ? new_addr : addr_ff;

  // Address register; also drives the matcher directly
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_ff <= pacf_pkg::ADDR_RESET;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  assign own_addr_o = addr_ff;

  // Checksum sequencer: a trigger restarts a pass over the settings
  wire crc_trig = boot_done_i || nvm_op_done_i;
  logic [15:0] crc_run;
  pacf_pkg::pacf_crc_state_type nxt_crc_st;
  // A byte still in flight while the request goes out belongs to the aborted image
  wire crc_take = (crc_st_ff == pacf_pkg::CRC_RUN) && !crc_trig && !crc_req_ff &&
                  nvm_byte_valid_i;

  always_comb begin
    nxt_crc_st = crc_st_ff;
    case (crc_st_ff)
      pacf_pkg::CRC_IDLE: begin
        if (crc_trig) begin
          nxt_crc_st = pacf_pkg::CRC_RUN;
        end
      end
      pacf_pkg::CRC_RUN: begin
        if (crc_take && nvm_byte_last_i) begin
          nxt_crc_st = pacf_pkg::CRC_LATCH;
        end
      end
      pacf_pkg::CRC_LATCH: begin
        nxt_crc_st = crc_trig ? pacf_pkg::CRC_RUN : pacf_pkg::CRC_IDLE;
      end
      default: begin
        nxt_crc_st = pacf_pkg::CRC_IDLE;
      end
    endcase
  end

  // Remainder engine
  pacf_crc16 u_crc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clr_i(crc_trig),
    .byte_valid_i(crc_take),
    .byte_i(nvm_byte_i),
    .crc_o(crc_run)
  );

  wire crc_done = (crc_st_ff == pacf_pkg::CRC_LATCH) && !crc_trig;
  wire [15:0] nxt_crc = crc_done ? crc_run : crc_ff;

  // Checksum state, result and request flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_st_ff <= pacf_pkg::CRC_IDLE;
      crc_ff <= pacf_pkg::CRC_INIT;
      crc_req_ff <= 1'b0;
      crc_busy_ff <= 1'b0;
    end else begin
      crc_st_ff <= nxt_crc_st;
      crc_ff <= nxt_crc;
      crc_req_ff <= crc_trig;
      crc_busy_ff <= (nxt_crc_st != pacf_pkg::CRC_IDLE);
    end
  end

  assign crc_req_o = crc_req_ff;
  assign crc_busy_o = crc_busy_ff;

  // Persistence and reserved bits; volatile, loaded by every injection write, cleared by reset
  wire nxt_fp = inj_wr ? wr_data_i[pacf_pkg::FAULT_PERSIST_BIT] : fault_persist_ff;
  wire nxt_wp = inj_wr ? wr_data_i[pacf_pkg::WARN_PERSIST_BIT] : warn_persist_ff;
  wire [15:0] nxt_rsv = inj_wr ? (wr_data_i & pacf_pkg::INJ_RSV_MASK) : inj_rsv_ff;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_persist_ff <= 1'b0;
      warn_persist_ff <= 1'b0;
      inj_rsv_ff <= pacf_pkg::INJ_RESET;
    end else begin
      fault_persist_ff <= nxt_fp;
      warn_persist_ff <= nxt_wp;
      inj_rsv_ff <= nxt_rsv;
    end
  end

  // One cell per injection bit, each independent of the others
  wire [15:0] inj_act;
  wire [15:0] inj_frc;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_inj
      if (pacf_pkg::INJ_MASK[g]) begin : g_on
        localparam bit IS_FAULT = (g >= pacf_pkg::FIRST_FAULT_BIT);
        wire persist = IS_FAULT ? fault_persist_ff : warn_persist_ff;
        pacf_inj_cell #(
          .ARMED_OFF(pacf_pkg::INJ_ARMED_OFF_MASK[g])
        ) u_cell (
          .mclk_i(mclk_i),
          .rst_n_i(rst_n_i),
          .wr_i(inj_wr),
          .wr_bit_i(wr_data_i[g]),
          .end_prev_i(persist),
          .resp_i(fault_resp_i[g]),
          .persist_i(persist),
          .conv_en_i(conv_en_i),
          .active_o(inj_act[g]),
          .force_o(inj_frc[g])
        );
      end else begin : g_off
        assign inj_act[g] = 1'b0;
        assign inj_frc[g] = 1'b0;
      end
    end
  endgenerate

  assign inj_force_o = inj_frc;

  // Read mux: address reads with bit 7 zero
  wire [15:0] addr_rd = {9'h000, addr_ff};
  wire [15:0] inj_rd = inj_act | inj_rsv_ff |
                       ({15'h0000, fault_persist_ff} << pacf_pkg::FAULT_PERSIST_BIT) |
                       ({15'h0000, warn_persist_ff} << pacf_pkg::WARN_PERSIST_BIT);
  wire [15:0] rd_sel = is_addr_cmd ? addr_rd :
                       is_crc_cmd ? crc_ff : inj_rd;
  wire [15:0] nxt_rd_data = rd_ok ? rd_sel : rd_data_ff;

  // Answer flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= 16'h0000;
      rd_ack_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_ack_ff <= rd_ok;
      cmd_err_ff <= wr_err || rd_err;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_ack_o = rd_ack_ff;
  assign cmd_err_o = cmd_err_ff;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  addr_write_a: assert property (
    addr_wr_ok && !addr_load_i |=> own_addr_o == $past(wr_data_i[6:0]))
    else $error("valid address write not applied next cycle");

  addr_refuse_a: assert property (
    wr_en_i && is_addr_cmd && addr_rsv && !addr_load_i |=> $stable(own_addr_o) && cmd_err_o)
    else $error("reserved address taken or not flagged");

  addr_bit7_a: assert property (
    rd_en_i && is_addr_cmd && !rd_word_i |=> rd_ack_o && rd_data_o[15:7] == 9'h000)
    else $error("address read shows upper bits");

  addr_load_a: assert property (
    addr_load_i |=> own_addr_o == ($past(use_pins) ? $past(pin_addr_i) : $past(nvm_addr_i)))
    else $error("address load took wrong source");

  crc_trig_a: assert property (
    crc_trig |=> crc_req_o && crc_busy_o)
    else $error("checksum recompute not started");

  crc_nowrite_a: assert property (
    wr_en_i && is_crc_cmd && !crc_done |=> cmd_err_o && crc_ff == $past(crc_ff))
    else $error("checksum write not refused");

  inj_off_a: assert property (
    !conv_en_i ##1 !conv_en_i |-> (inj_force_o & ~pacf_pkg::INJ_ARMED_OFF_MASK) == 16'h0000)
    else $error("injection forced while conversion off");

  inj_armed_a: assert property (
    inj_act[pacf_pkg::INJECT_INPUT_LOCKOUT] |=> inj_force_o[pacf_pkg::INJECT_INPUT_LOCKOUT])
    else $error("input lockout injection not forced");

  inj_oneshot_a: assert property (
    !inj_wr && !fault_persist_ff && fault_resp_i[pacf_pkg::INJECT_OVERTEMP_FAULT]
    |=> !inj_act[pacf_pkg::INJECT_OVERTEMP_FAULT])
    else $error("non-persistent fault did not clear");

  inj_persist_a: assert property (
    !inj_wr && warn_persist_ff |=> inj_act[4:0] == $past(inj_act[4:0]))
    else $error("persistent warning changed without write");

  inj_set_a: assert property (
    inj_wr |=> (inj_act & $past(wr_data_i)) == ($past(wr_data_i) & pacf_pkg::INJ_MASK))
    else $error("written injection bits not active");

  addr_rsv_low_a: assert property (
    wr_en_i && is_addr_cmd && !addr_load_i &&
    (new_addr == pacf_pkg::RSV_ADDR_A || new_addr == pacf_pkg::RSV_ADDR_B)
    |=> own_addr_o == $past(own_addr_o) && cmd_err_o)
    else $error("low reserved address taken");

  addr_rsv_high_a: assert property (
    wr_en_i && is_addr_cmd && !addr_load_i &&
    (new_addr == pacf_pkg::RSV_ADDR_C || new_addr == pacf_pkg::RSV_ADDR_D)
    |=> own_addr_o == $past(own_addr_o) && cmd_err_o)
    else $error("high reserved address taken");

  crc_read_a: assert property (
    rd_en_i && is_crc_cmd && rd_word_i |=> rd_ack_o && rd_data_o == $past(crc_ff))
    else $error("checksum read returned wrong word");

  crc_end_a: assert property (
    crc_done |=> !crc_busy_o && crc_ff == $past(crc_run))
    else $error("checksum pass did not finish");

  temp_fault_on_a: assert property (
    conv_en_i && inj_act[pacf_pkg::INJECT_OVERTEMP_FAULT]
    |=> inj_force_o[pacf_pkg::INJECT_OVERTEMP_FAULT])
    else $error("overtemperature injection not forced");

  vin_ov_on_a: assert property (
    conv_en_i && inj_act[pacf_pkg::INJECT_INPUT_OVERVOLTAGE]
    |=> inj_force_o[pacf_pkg::INJECT_INPUT_OVERVOLTAGE])
    else $error("input overvoltage injection not forced");

  vout_uv_on_a: assert property (
    conv_en_i && inj_act[pacf_pkg::INJECT_OUTPUT_UNDERVOLTAGE]
    |=> inj_force_o[pacf_pkg::INJECT_OUTPUT_UNDERVOLTAGE])
    else $error("output undervoltage injection not forced");

  ocw_on_a: assert property (
    conv_en_i && inj_act[pacf_pkg::INJECT_OVERCURRENT_WARNING]
    |=> inj_force_o[pacf_pkg::INJECT_OVERCURRENT_WARNING])
    else $error("overcurrent warning injection not forced");

  vout_ov_off_a: assert property (
    inj_act[pacf_pkg::INJECT_OUTPUT_OVERVOLTAGE]
    |=> inj_force_o[pacf_pkg::INJECT_OUTPUT_OVERVOLTAGE])
    else $error("output overvoltage injection not forced");

  warn_oneshot_a: assert property (
    !inj_wr && !warn_persist_ff && fault_resp_i[pacf_pkg::INJECT_OUTPUT_OVERVOLTAGE_WARNING]
    |=> !inj_act[pacf_pkg::INJECT_OUTPUT_OVERVOLTAGE_WARNING])
    else $error("non-persistent warning did not clear");

endmodule

`default_nettype wire

// ===== pacf_crc16.sv
/*
  Running CRC-16 over a byte stream, most significant bit first.
  Assumes the caller clears it before each pass over the settings.
*/
`timescale 1ns/1ps
`default_nettype none

module pacf_crc16 (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Stream
  input wire logic clr_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Result
  output logic [15:0] crc_o
);

  // One byte folded into the remainder
  function automatic logic [15:0] step(input logic [15:0] crc, input logic [7:0] din);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ din[i]) begin
        c = {c[14:0], 1'b0} ^ pacf_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  logic [15:0] nxt_crc;

  assign nxt_crc = clr_i ? pacf_pkg::CRC_INIT :
                   byte_valid_i ? step(crc_o, byte_i) : crc_o;

  // Remainder register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_o <= pacf_pkg::CRC_INIT;
    end else begin
      crc_o <= nxt_crc;
    end
  end

endmodule

`default_nettype wire

// ===== pacf_inj_cell.sv
/*
  One fault or warning injection bit: holds the injected state and forces
  its detector. Assumes the protection logic pulses a response input once
  per fault response for this detector.
*/
`timescale 1ns/1ps
`default_nettype none

module pacf_inj_cell #(
  parameter bit ARMED_OFF = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register write
  input wire logic wr_i,
  input wire logic wr_bit_i,
  input wire logic end_prev_i,
  // Protection side
  input wire logic resp_i,
  input wire logic persist_i,
  input wire logic conv_en_i,
  // State
  output logic active_o,
  output logic force_o
);

  logic keep;
  logic nxt_active;
  logic nxt_force;

  // A write ends persisted injections, a one starts one; set beats clear
  assign keep = wr_i ? (active_o & ~end_prev_i) : active_o;
  assign nxt_active = (wr_i & wr_bit_i) | (keep & ~(resp_i & ~persist_i));
  assign nxt_force = active_o & (ARMED_OFF | conv_en_i);

  // State and forcing flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= 1'b0;
      force_o <= 1'b0;
    end else begin
      active_o <= nxt_active;
      force_o <= nxt_force;
    end
  end

endmodule

`default_nettype wire

// ===== pacf_nvm_model.sv
/*
  Model of the NVM engine that streams the settings image for the checksum.
  Assumes the stream request is a one-cycle pulse and that a new request
  aborts any image still in flight.
*/
`timescale 1ns/1ps
`default_nettype none

module pacf_nvm_model #(
  parameter int NB = 6
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control from the block and the bench
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic [7:0] salt_i,
  // Byte stream
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic byte_last_o
);
  logic [7:0] idx_ff;
  logic run_ff;

  // Send the image after a request, stalling at random when slow
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff <= 1'b0;
      idx_ff <= 8'h00;
      byte_valid_o <= 1'b0;
      byte_o <= 8'h00;
      byte_last_o <= 1'b0;
    end else if (req_i) begin
      run_ff <= 1'b1;
      idx_ff <= 8'h00;
      byte_valid_o <= 1'b0;
      byte_last_o <= 1'b0;
    end else if (run_ff && (!slow_i || $urandom_range(1, 0) == 1)) begin
      byte_valid_o <= 1'b1;
      byte_o <= salt_i ^ (idx_ff * 8'h1d);
      byte_last_o <= (idx_ff == 8'(NB - 1));
      idx_ff <= idx_ff + 8'h01;
      run_ff <= (idx_ff != 8'(NB - 1));
    end else begin
      // Stale data is never held on the byte lines
      byte_valid_o <= 1'b0;
      byte_last_o <= 1'b0;
      byte_o <= ~byte_o;
    end
  end
endmodule

`default_nettype wire

// ===== pacf_pkg.sv
/*
  Shared constants for the bus-address, settings-checksum and fault-injection
  command group: command codes, field positions, reserved addresses, CRC setup.
  Assumes a command front end that decodes bus transactions into strobes.
*/
package pacf_pkg;

  // Command codes
  localparam logic [7:0] CMD_BUS_ADDRESS_SELECT = 8'hef;
  localparam logic [7:0] CMD_SETTINGS_CRC = 8'hf0;
  localparam logic [7:0] CMD_FAULT_INJECTION = 8'hf1;

  // Bus-address field layout
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  // Addresses reserved by the bus specification
  localparam logic [6:0] RSV_ADDR_A = 7'h0c;
  localparam logic [6:0] RSV_ADDR_B = 7'h28;
  localparam logic [6:0] RSV_ADDR_C = 7'h37;
  localparam logic [6:0] RSV_ADDR_D = 7'h61;

  // Pin-override mask bit that selects the strapped address
  localparam int OVR_ADDRESS_BIT = 8;

  // Fault-injection field positions
  localparam int FAULT_PERSIST_BIT = 15;
  localparam int WARN_PERSIST_BIT = 7;
  localparam int INJECT_OVERTEMP_FAULT = 14;
  localparam int INJECT_OVERCURRENT_FAULT = 12;
  localparam int INJECT_INPUT_LOCKOUT = 11;
  localparam int INJECT_INPUT_OVERVOLTAGE = 10;
  localparam int INJECT_OUTPUT_UNDERVOLTAGE = 9;
  localparam int INJECT_OUTPUT_OVERVOLTAGE = 8;
  localparam int INJECT_OVERCURRENT_WARNING = 4;
  localparam int INJECT_INPUT_UNDERVOLTAGE_WARNING = 3;
  localparam int INJECT_OUTPUT_UNDERVOLTAGE_WARNING = 1;
  localparam int INJECT_OUTPUT_OVERVOLTAGE_WARNING = 0;
  localparam int FIRST_FAULT_BIT = 8;

  // Field masks
  localparam logic [15:0] INJ_MASK = 16'h5f1b;
  localparam logic [15:0] INJ_RSV_MASK = 16'h2064;
  localparam logic [15:0] INJ_ARMED_OFF_MASK = 16'h0900;
  localparam logic [15:0] INJ_RESET = 16'h0000;

  // Settings checksum
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // Checksum sequencer states
  typedef enum logic [1:0] {
    CRC_IDLE,
    CRC_RUN,
    CRC_LATCH
  } pacf_crc_state_type;

endpackage

// ===== test_pmbus_addr_crc_fault_sim.sv
/*
  Self-checking bench for the command register group: address, checksum
  and fault injection. Assumes the NVM stream model beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_pmbus_addr_crc_fault_sim;
  localparam int NB = 6;
  localparam logic [6:0] RSV [4] = '{7'h0c, 7'h28, 7'h37, 7'h61};
  // Refused operations: write flag, word flag, command code
  localparam logic [9:0] REFUSED [7] = '{10'h3ef, 10'h1ef, 10'h3f0, 10'h0f0,
    10'h2f1, 10'h0f1, 10'h13c};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic wr_word_i = 1'b0;
  logic [15:0] wr_data_i = 16'h0000;
  logic rd_en_i = 1'b0;
  logic rd_word_i = 1'b0;
  logic addr_load_i = 1'b0;
  logic [6:0] nvm_addr_i = 7'h00;
  logic [6:0] pin_addr_i = 7'h00;
  logic [15:0] pin_override_i = 16'h0000;
  logic boot_done_i = 1'b0;
  logic nvm_op_done_i = 1'b0;
  logic conv_en_i = 1'b1;
  logic [15:0] fault_resp_i = 16'h0000;
  logic slow = 1'b0;
  logic [7:0] salt = 8'h00;
  wire logic [15:0] rd_data_o;
  wire logic rd_ack_o;
  wire logic cmd_err_o;
  wire logic [6:0] own_addr_o;
  wire logic crc_req_o;
  wire logic crc_busy_o;
  wire logic [15:0] inj_force_o;
  wire logic bv;
  wire logic [7:0] bt;
  wire logic bl;
  logic [16:0] exp_q [$];
  int mismatches = 0;
  int n_compared = 0;
  logic [6:0] a;
  logic [31:0] seed_ret;

  always #20 mclk_i = ~mclk_i;

  pacf_cmd_regs i_pacf_cmd_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cmd_code_i(cmd_code_i), .wr_en_i(wr_en_i), .wr_word_i(wr_word_i),
    .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_word_i(rd_word_i),
    .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o), .cmd_err_o(cmd_err_o),
    .addr_load_i(addr_load_i), .nvm_addr_i(nvm_addr_i), .pin_addr_i(pin_addr_i),
    .pin_override_i(pin_override_i), .own_addr_o(own_addr_o),
    .boot_done_i(boot_done_i), .nvm_op_done_i(nvm_op_done_i),
    .nvm_byte_valid_i(bv), .nvm_byte_i(bt), .nvm_byte_last_i(bl),
    .crc_req_o(crc_req_o), .crc_busy_o(crc_busy_o), .conv_en_i(conv_en_i),
    .fault_resp_i(fault_resp_i), .inj_force_o(inj_force_o));

  pacf_nvm_model #(.NB(NB)) i_pacf_nvm_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_i(crc_req_o), .slow_i(slow), .salt_i(salt), .byte_valid_o(bv),
    .byte_o(bt), .byte_last_o(bl));

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (exp_q.size() != 0) mismatches++;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One transaction strobe, then an idle cycle so no strobe toggles twice at once
  task automatic op(input logic w, input logic [7:0] code, input logic word,
                    input logic [15:0] d);
    cmd_code_i = code;
    wr_en_i = w;
    rd_en_i = !w;
    wr_word_i = word;
    rd_word_i = word;
    wr_data_i = d;
    @(negedge mclk_i);
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic err);
    if (err) exp_q.push_back({1'b1, 16'h0000});
    op(1'b1, code, code != pacf_pkg::CMD_BUS_ADDRESS_SELECT, d);
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    exp_q.push_back({1'b0, exp});
    op(1'b0, code, code != pacf_pkg::CMD_BUS_ADDRESS_SELECT, 16'h0000);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk_i);
    s = 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Expected checksum of the image that the stream model sends
  function automatic logic [15:0] crc_of(input logic [7:0] s);
    logic [15:0] c;
    logic [7:0] b;
    c = pacf_pkg::CRC_INIT;
    for (int i = 0; i < NB; i++) begin
      b = s ^ (8'(i) * 8'h1d);
      for (int k = 7; k >= 0; k--) begin
        c = (c[15] ^ b[k]) ? {c[14:0], 1'b0} ^ pacf_pkg::CRC_POLY : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Checksum pass: trigger, wait for the sequencer to go idle, read it
  task automatic crc_pass(ref logic trig, input logic [7:0] s);
    salt = s;
    pulse(trig);
    for (int n = 0; n < 200 && crc_busy_o !== 1'b0; n++) @(negedge mclk_i);
    rd(pacf_pkg::CMD_SETTINGS_CRC, crc_of(s));
  endtask

  // Answers are matched in order against the noted expectations
  always @(negedge mclk_i) begin
    if (rst_n_i && (rd_ack_o === 1'b1 || cmd_err_o === 1'b1)) begin
      if (exp_q.size() == 0) check({15'h0000, cmd_err_o}, 16'hffff);
      else begin
        check({15'h0000, cmd_err_o}, {15'h0000, exp_q[0][16]});
        if (exp_q[0][16] === 1'b0) check(rd_data_o, exp_q[0][15:0]);
        void'(exp_q.pop_front());
      end
    end
  end

  // Watchdog
  initial begin
    #(40 * 5000);
    mismatches++;
    complete_run;
  end

  initial begin
    seed_ret = $urandom(32'h144c5561);
    wait_cycles(5);
    rst_n_i = 1'b1;
    check({9'h000, own_addr_o}, 16'h0000);
    check(inj_force_o, pacf_pkg::INJ_RESET);
    // Address load from the stored value, then from the straps
    nvm_addr_i = 7'h1a;
    pin_addr_i = 7'h4b;
    pin_override_i = 16'hfeff;
    pulse(addr_load_i);
    check({9'h000, own_addr_o}, 16'h001a);
    pin_override_i = 16'h0100;
    pulse(addr_load_i);
    check({9'h000, own_addr_o}, 16'h004b);
    rd(pacf_pkg::CMD_BUS_ADDRESS_SELECT, 16'h004b);
    // Random addresses take effect from the cycle after the write; bit 7 never reads back
    for (int i = 0; i < 8; i++) begin
      a = 7'($urandom);
      if (a inside {RSV[0], RSV[1], RSV[2], RSV[3]}) a = 7'h25;
      wr(pacf_pkg::CMD_BUS_ADDRESS_SELECT, {8'h00, 1'b1, a}, 1'b0);
      check({9'h000, own_addr_o}, {9'h000, a});
      rd(pacf_pkg::CMD_BUS_ADDRESS_SELECT, {9'h000, a});
    end
    // Reserved addresses are refused and the old address kept
    for (int i = 0; i < 4; i++) begin
      wr(pacf_pkg::CMD_BUS_ADDRESS_SELECT, {9'h000, RSV[i]}, 1'b1);
      check({9'h000, own_addr_o}, {9'h000, a});
    end
    // Wrong transaction kinds and an unmapped code are refused
    for (int i = 0; i < 7; i++) begin
      exp_q.push_back({1'b1, 16'h0000});
      op(REFUSED[i][9], REFUSED[i][7:0], REFUSED[i][8], 16'h0033);
    end
    wait_cycles(1);
    check({9'h000, own_addr_o}, {9'h000, a});
    // Checksum at boot, then an aborted pass restarted by a store
    crc_pass(boot_done_i, 8'($urandom));
    slow = 1'b1;
    pulse(boot_done_i);
    wait_cycles(3);
    crc_pass(nvm_op_done_i, 8'($urandom));
    // All injections together, reserved bits stored but inert
    wr(pacf_pkg::CMD_FAULT_INJECTION, 16'h0001, 1'b0);
    wr(pacf_pkg::CMD_FAULT_INJECTION, 16'h7f7e, 1'b0);
    wait_cycles(2);
    check(inj_force_o, pacf_pkg::INJ_MASK);
    rd(pacf_pkg::CMD_FAULT_INJECTION, 16'h7f7f);
    // With conversion off only lockout and output overvoltage force
    conv_en_i = 1'b0;
    wait_cycles(3);
    check(inj_force_o, pacf_pkg::INJ_ARMED_OFF_MASK);
    conv_en_i = 1'b1;
    // One response ends a non-persistent fault and warning
    fault_resp_i = 16'h4001;
    wait_cycles(1);
    fault_resp_i = 16'h0000;
    wait_cycles(3);
    check(inj_force_o, 16'h1f1a);
    // Persistent injections outlive responses until rewritten
    wr(pacf_pkg::CMD_FAULT_INJECTION, 16'h9090, 1'b0);
    fault_resp_i = 16'h1010;
    wait_cycles(1);
    fault_resp_i = 16'h0000;
    wait_cycles(3);
    check(inj_force_o, 16'h1f1a);
    wr(pacf_pkg::CMD_FAULT_INJECTION, 16'h0000, 1'b0);
    wait_cycles(3);
    check(inj_force_o, 16'h0000);
    wait_cycles(4);
    complete_run;
  end
endmodule

`default_nettype wire
